/* File: logic/sdi_pkg.sv */
package sdi_pkg;

   // word widths
   localparam int WORD_W      = 10;
   localparam int NARROW_W    = 8;

   // data type select codes on the type pins
   localparam logic [1:0] TYPE_COMPONENT = 2'h0;
   localparam logic [1:0] TYPE_NTSC      = 2'h1;
   localparam logic [1:0] TYPE_PAL       = 2'h2;

   // clipping bounds inside timing reference characters
   localparam logic [9:0] CLIP_LO_MAX   = 10'h003;
   localparam logic [9:0] CLIP_LO_VAL   = 10'h000;
   localparam logic [9:0] CLIP_HI_MIN   = 10'h3FC;
   localparam logic [9:0] CLIP_HI_VAL   = 10'h3FF;
   localparam logic [7:0] NARROW_ONES   = 8'hFF;

   // position of the h bit in the xyz word (0 = start of active video)
   localparam int XYZ_H_BIT   = 6;

   // scrambler taps for x^9 + x^4 + 1
   localparam int SCR_LEN     = 9;
   localparam int SCR_TAP_A   = 8;
   localparam int SCR_TAP_B   = 3;
   localparam logic [8:0] SCR_RESET = 9'h000;

   // serial bits per parallel word
   localparam int BIT_RATIO   = 10;

   // timing
   localparam int CLK_PERIOD_NS     = 100;
   localparam int LOCK_TIME_NS      = 75000;
   localparam int LOCK_MAX_CYC      = LOCK_TIME_NS / CLK_PERIOD_NS;
   localparam int CLK_START_WAIT_NS = 30000;
   localparam int CLK_START_WAIT_CYC =
      (CLK_START_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // good reference periods in a row before lock is declared
   localparam int LOCK_PERIODS = 4;

   // power-on sequencing
   typedef enum logic {
      ST_RESET,
      ST_RUN
   } por_state_t;

endpackage : sdi_pkg

/* File: logic/sdi_serializer_encoder.sv */
`timescale 1ns/1ps

// How it works
// RULE1: takes 8 or 10 bit parallel words, selected by the narrow-word input.
// RULE2: 8 bit words widen to 10 bits, rule chosen by component, ntsc or pal.
// RULE3: trs detection only runs while the active-low detect enable is low.
// RULE4: detector flags trs words and active video toward the scrambler.
// RULE5: inside trs characters, values 000h to 003h become 000h.
// RULE6: inside trs characters, values 3FCh to 3FFh become 3FFh.
// RULE7: clipping happens before the word enters the scrambler.
// RULE8: stream scrambled with x^9 + x^4 + 1, then serialized.
// RULE9: scrambled bits converted to nrzi with x + 1 before the driver.
// RULE10: each 10 bit word leaves least significant bit first.
// RULE11: bit clock is ten times the word clock, locked to it.
// RULE12: lock indication rises within 75 us of the first word clock edge.
// RULE13: lock output high while locked, low otherwise.
// RULE14: while unlocked the serial driver holds a static level.
// RULE15: power-on reset clears detector, registers, counters, scrambler; output off (period_r loads CNT_MAX instead).
// RULE16: serial pair is released (not driven) during power-on reset.
// RULE17: device stays in reset until the word clock starts toggling.
// RULE18: source should wait 30 us after supply is good before clocking.
// RULE19: one input word is captured on each rising word clock edge. (The first rise, which leaves reset, captures no word.)
// RULE20: nrzi toggles on each one, holds on zero, continuous across words.
module sdi_serializer_encoder #(
   parameter int LOCK_PERIODS = sdi_pkg::LOCK_PERIODS
) (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   // parallel video side
   input  wire logic       word_clk,
   input  wire logic [9:0] word_in,
   input  wire logic       narrow_word,
   input  wire logic [1:0] data_type,
   input  wire logic       trs_detect_en_n,
   // status
   output logic            lock_detect,
   output logic            trs_found,
   output logic            video_active,
   // serial pair: true, complement, shared enable (low = driven)
   output logic            serial_out_pair_p,
   output logic            serial_out_pair_n,
   output logic            serial_out_pair_oe_n
);

   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(sdi_pkg::BIT_RATIO - 1);
   localparam logic [CNT_W-1:0] BITS_FULL   = CNT_W'(sdi_pkg::BIT_RATIO);
   localparam logic [CNT_W-1:0] CNT_ZERO    = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE     = 4'h1;
   localparam logic [CNT_W-1:0] CNT_MAX     = 4'hF;
   localparam int GOOD_W = $clog2(LOCK_PERIODS + 1);
   localparam logic [GOOD_W-1:0] GOOD_TARGET = GOOD_W'(LOCK_PERIODS);
   localparam logic [GOOD_W-1:0] GOOD_ZERO   = '0;
   localparam logic [GOOD_W-1:0] GOOD_ONE    = GOOD_W'(1);

   // widen an 8 bit word by the rule of its data type
   function automatic logic [9:0] widen(input logic [7:0] d, input logic [1:0] t);
      logic [9:0] w;
      w = {d, 2'b00};
      case (t)
         sdi_pkg::TYPE_NTSC,
         sdi_pkg::TYPE_PAL: begin
            // composite sync tip carries all ones into the added bits
            if (d == sdi_pkg::NARROW_ONES) begin
               w = sdi_pkg::CLIP_HI_VAL;
            end
         end
         sdi_pkg::TYPE_COMPONENT: begin
            // component keeps 3FCh, which stays a legal preamble code
            w = {d, 2'b00};
         end
         default: begin
            w = {d, 2'b00};
         end
      endcase
      return w;
   endfunction : widen

   function automatic logic is_low(input logic [9:0] w);
      return w <= sdi_pkg::CLIP_LO_MAX;
   endfunction : is_low

   function automatic logic is_high(input logic [9:0] w);
      return w >= sdi_pkg::CLIP_HI_MIN;
   endfunction : is_high

   // force the reserved extremes to their canonical codes
   function automatic logic [9:0] clip(input logic [9:0] w);
      logic [9:0] c;
      c = w;
      if (is_low(w)) begin
         c = sdi_pkg::CLIP_LO_VAL;
      end else if (is_high(w)) begin
         c = sdi_pkg::CLIP_HI_VAL;
      end
      return c;
   endfunction : clip

   // state
   sdi_pkg::por_state_t    por_r;
   logic                   word_clk_d_r;
   logic [9:0]             win0_r;
   logic [9:0]             win1_r;
   logic [9:0]             win2_r;
   logic                   flag0_r;
   logic                   flag1_r;
   logic                   xyz_next_r;
   logic [CNT_W-1:0]       period_r;
   logic [GOOD_W-1:0]      good_r;
   logic                   lock_r;
   logic [9:0]             shift_r;
   logic [CNT_W-1:0]       bits_left_r;
   logic [8:0]             scr_r;
   logic                   nrzi_r;
   logic                   trs_found_r;
   logic                   video_active_r;
   logic                   oe_n_r;
   logic                   ser_n_r;

   // next values
   sdi_pkg::por_state_t    por_nxt;
   logic [CNT_W-1:0]       period_nxt;
   logic [GOOD_W-1:0]      good_nxt;
   logic                   lock_nxt;
   logic [9:0]             shift_nxt;
   logic [CNT_W-1:0]       bits_left_nxt;
   logic                   video_nxt;
   logic [8:0]             scr_nxt;
   logic                   nrzi_nxt;

   // decode
   wire                    running    = (por_r == sdi_pkg::ST_RUN);
   wire                    word_rise  = word_clk & ~word_clk_d_r;
   wire                    take_word  = word_rise & running;
   wire [9:0]              word_full  = narrow_word ?                      // [RULE1]
                                        widen(word_in[9:2], data_type) :  // [RULE2]
                                        word_in;
   // the word clock is sampled as data; a rise is seen at the first core clock edge that finds it high
   wire                    win2_high  = is_high(win2_r);
   wire                    win1_low   = is_low(win1_r);
   wire                    win0_low   = is_low(win0_r);
   wire                    preamble   = win2_high & win1_low & win0_low;
   wire                    trs_hit    = ~trs_detect_en_n & preamble;       // [RULE3]
   wire                    oldest_trs = trs_hit | flag1_r;
   wire                    xyz_h_bit  = win0_r[sdi_pkg::XYZ_H_BIT];
   wire                    good_seen  = (good_nxt == GOOD_TARGET);
   wire [9:0]              word_clean = oldest_trs ? clip(win2_r) : win2_r; // [RULE5] [RULE6]
   wire                    period_ok  = (period_r == PERIOD_LAST);
   wire                    shifting   = lock_r & (bits_left_r != CNT_ZERO);
   wire                    data_bit   = shift_r[0];                         // [RULE10]
   wire                    scr_bit    = data_bit ^ scr_r[sdi_pkg::SCR_TAP_A] ^
                                        scr_r[sdi_pkg::SCR_TAP_B];          // [RULE8]

   // power-on sequencing: held in reset until the word clock first rises
   always_comb begin
      por_nxt = por_r;
      case (por_r)
         sdi_pkg::ST_RESET: begin
            if (word_rise) begin
               por_nxt = sdi_pkg::ST_RUN;                                   // [RULE17]
            end
         end
         sdi_pkg::ST_RUN: begin
            por_nxt = sdi_pkg::ST_RUN;
         end
         default: begin
            por_nxt = sdi_pkg::ST_RESET;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         por_r        <= sdi_pkg::ST_RESET;
         word_clk_d_r <= 1'b0;
      end else begin
         por_r        <= por_nxt;
         word_clk_d_r <= word_clk;
      end
   end

   // input window, three words deep so the whole preamble is seen at once
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin                                                     // [RULE15]
         win0_r  <= 10'h000;
         win1_r  <= 10'h000;
         win2_r  <= 10'h000;
      end else if (take_word) begin
         win0_r  <= word_full;                                              // [RULE19]
         win1_r  <= win0_r;
         win2_r  <= win1_r;
      end
   end

   // both low words of a preamble still need clipping after the high one
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag0_r <= 1'b0;
         flag1_r <= 1'b0;
      end else if (take_word) begin
         flag0_r <= trs_hit;                                                // [RULE5]
         flag1_r <= trs_hit | flag0_r;                                      // [RULE5]
      end
   end

   // video marker follows the h bit of the word after each detected preamble
   always_comb begin
      video_nxt = video_active_r;
      if (take_word & xyz_next_r) begin
         video_nxt = ~xyz_h_bit;                                            // [RULE4]
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         trs_found_r <= 1'b0;
      end else begin
         trs_found_r <= take_word & trs_hit;                                // [RULE4]
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         xyz_next_r <= 1'b0;
      end else if (take_word) begin
         xyz_next_r <= trs_hit;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         video_active_r <= 1'b0;
      end else begin
         video_active_r <= video_nxt;                                       // [RULE4]
      end
   end

   // reference period check stands in for the loop's phase detector
   always_comb begin
      period_nxt = period_r;
      good_nxt   = good_r;
      if (word_rise) begin
         period_nxt = CNT_ZERO;
         if (!period_ok) begin
            good_nxt = GOOD_ZERO;
         end else if (good_r != GOOD_TARGET) begin
            good_nxt = good_r + GOOD_ONE;
         end
      end else if (period_r != CNT_MAX) begin
         period_nxt = period_r + CNT_ONE;
      end
   end

   // lock follows the run of good periods; one bad period drops it at once
   always_comb begin
      lock_nxt = lock_r;
      if (running | word_rise) begin
         lock_nxt = good_seen;                                              // [RULE13]
      end
   end

   // a few periods of exactly ten bit clocks lock well inside the limit
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         period_r <= CNT_MAX;
         good_r   <= GOOD_ZERO;
         lock_r   <= 1'b0;
      end else if (running | word_rise) begin
         period_r <= period_nxt;                                            // [RULE11]
         good_r   <= good_nxt;
         lock_r   <= lock_nxt;                                              // [RULE12] [RULE13]
      end
   end

   // serializer: clipped word loads at the word edge, then shifts lsb first
   always_comb begin
      shift_nxt     = shift_r;
      bits_left_nxt = bits_left_r;
      if (take_word) begin
         shift_nxt     = word_clean;                                        // [RULE7]
         bits_left_nxt = BITS_FULL;
      end else if (shifting) begin
         shift_nxt     = {1'b0, shift_r[9:1]};                              // [RULE10]
         bits_left_nxt = bits_left_r - CNT_ONE;
      end
   end

   // a reload wins over the last shift; that bit was already scrambled
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_r     <= 10'h000;
         bits_left_r <= CNT_ZERO;
      end else begin
         shift_r     <= shift_nxt;
         bits_left_r <= bits_left_nxt;
      end
   end

   // scrambler and nrzi only advance with a serial bit, so the pair is
   // static whenever the loop is out of lock
   always_comb begin
      scr_nxt  = scr_r;
      nrzi_nxt = nrzi_r;
      if (shifting) begin
         scr_nxt  = {scr_r[7:0], scr_bit};                                  // [RULE8]
         nrzi_nxt = nrzi_r ^ scr_bit;                                       // [RULE9] [RULE20]
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         scr_r  <= sdi_pkg::SCR_RESET;                                      // [RULE15]
         nrzi_r <= 1'b0;
      end else begin
         scr_r  <= scr_nxt;
         nrzi_r <= nrzi_nxt;                                                // [RULE14]
      end
   end

   // complement leg is its own register so both legs switch together
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ser_n_r <= 1'b1;                                                   // [RULE16]
      end else begin
         ser_n_r <= ~nrzi_nxt;                                              // [RULE9]
      end
   end

   // output pair released until the first word clock edge
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         oe_n_r <= 1'b1;                                                    // [RULE16]
      end else begin
         oe_n_r <= ~running;                                                // [RULE16]
      end
   end

   assign lock_detect          = lock_r;
   assign trs_found            = trs_found_r;
   assign video_active         = video_active_r;
   assign serial_out_pair_p    = nrzi_r;
   assign serial_out_pair_n    = ser_n_r;
   assign serial_out_pair_oe_n = oe_n_r;

endmodule : sdi_serializer_encoder

/* File: testbench/sdi_serializer_encoder_asserts.sv */
`timescale 1ns/1ps
module sdi_serializer_encoder_asserts #(
   parameter int LOCK_PERIODS = sdi_pkg::LOCK_PERIODS
) (
   // clock and reset
   input wire logic       core_clk,
   input wire logic       rst_n,
   // parallel side
   input wire logic       word_clk,
   input wire logic [9:0] word_in,
   input wire logic       narrow_word,
   input wire logic [1:0] data_type,
   input wire logic       trs_detect_en_n,
   // status and serial pair
   input wire logic       lock_detect,
   input wire logic       trs_found,
   input wire logic       video_active,
   input wire logic       serial_out_pair_p,
   input wire logic       serial_out_pair_n,
   input wire logic       serial_out_pair_oe_n
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   AST_STATIC: assert property (!lock_detect |=> $stable(serial_out_pair_p))
      else $error("serial output moved while unlocked");
   AST_LOCK_EDGE: assert property (
      $rose(lock_detect) |-> $past(word_clk) && !$past(word_clk, 2))
      else $error("lock rose away from a word clock rise");
   AST_LOCK_TIME: assert property (
      $fell(serial_out_pair_oe_n) |-> ##[0:750] lock_detect)
      else $error("lock not reached in time");
   AST_TRS_GAP: assert property (trs_found |=> !trs_found [*8])
      else $error("trs pulse too long or too close");
   AST_TRS_EN: assert property (trs_found |-> !$past(trs_detect_en_n))
      else $error("trs flagged with detection disabled");
   AST_VIDEO: assert property (
      $changed(video_active) |-> $past(word_clk) && !$past(word_clk, 2))
      else $error("video flag moved away from a word edge");
   AST_START: assert property (
      word_clk && !$past(word_clk) |-> ##[1:2] !serial_out_pair_oe_n)
      else $error("output not enabled after word clock start");
   AST_WAIT: assert property (
      serial_out_pair_oe_n && !word_clk |=> serial_out_pair_oe_n)
      else $error("output enabled without word clock");
   AST_OFF_UNLOCKED: assert property (serial_out_pair_oe_n |-> !lock_detect)
      else $error("lock shown while still in reset state");
endmodule : sdi_serializer_encoder_asserts

bind sdi_serializer_encoder sdi_serializer_encoder_asserts #(
   .LOCK_PERIODS(LOCK_PERIODS)
) i_chk (
   .core_clk(core_clk), .rst_n(rst_n), .word_clk(word_clk), .word_in(word_in),
   .narrow_word(narrow_word), .data_type(data_type), .trs_detect_en_n(trs_detect_en_n),
   .lock_detect(lock_detect), .trs_found(trs_found), .video_active(video_active),
   .serial_out_pair_p(serial_out_pair_p), .serial_out_pair_n(serial_out_pair_n),
   .serial_out_pair_oe_n(serial_out_pair_oe_n)
);

/* File: testbench/sdi_video_source.sv */
`timescale 1ns/1ps
module sdi_video_source (
   // control
   input  wire logic       core_clk,
   input  wire logic       run,
   input  wire logic [4:0] period,
   input  wire logic [9:0] next_word,
   // parallel side
   output logic            word_clk = 1'b0,
   output logic [9:0]      word_in = 10'h2AA,
   output logic            took = 1'b0
);
   logic [4:0] cnt_r = 5'h00;
   // clock stands still outside running; idle data flips so it never looks stable
   always @(negedge core_clk) begin
      if (!run) begin
         cnt_r    <= 5'h00;
         word_clk <= 1'b0;
         took     <= 1'b0;
         word_in  <= ~word_in;
      end else begin
         cnt_r    <= (cnt_r >= period - 5'h01) ? 5'h00 : cnt_r + 5'h01;
         word_clk <= (cnt_r < 5'h05);
         took     <= (cnt_r == 5'h00);
         if (cnt_r == 5'h00) word_in <= next_word;
      end
   end
endmodule : sdi_video_source

/* File: testbench/sdi_serializer_encoder_tb_top.sv */
`timescale 1ns/1ps
module sdi_serializer_encoder_tb_top;
   logic        core_clk, rst_n, run, narrow_word, trs_detect_en_n, word_clk, took;
   logic        lock_detect, trs_found, video_active, ser_p, ser_n, ser_oe_n;
   logic [4:0]  period;
   logic [9:0]  next_word, word_in;
   logic [1:0]  data_type;
   logic [8:0]  hist = 9'h000;
   logic [39:0] sh = '0;
   logic [29:0] exp30 = '0;
   logic        pp = 1'b0;
   logic        hit = 1'b0;
   int          errors = 0;
   int          checked = 0;
   int          trs_cnt = 0;

   sdi_video_source i_src (.core_clk(core_clk), .run(run), .period(period),
      .next_word(next_word), .word_clk(word_clk), .word_in(word_in), .took(took));
   sdi_serializer_encoder i_dut (.core_clk(core_clk), .rst_n(rst_n), .word_clk(word_clk),
      .word_in(word_in), .narrow_word(narrow_word), .data_type(data_type),
      .trs_detect_en_n(trs_detect_en_n), .lock_detect(lock_detect), .trs_found(trs_found),
      .video_active(video_active), .serial_out_pair_p(ser_p), .serial_out_pair_n(ser_n),
      .serial_out_pair_oe_n(ser_oe_n));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   // descramble the wire, so checks do not hang on the pipeline depth
   always @(negedge core_clk) begin
      if (lock_detect === 1'b1) begin
         hist <= {hist[7:0], ser_p ^ pp};
         sh   <= {ser_p ^ pp ^ hist[8] ^ hist[3], sh[39:1]};
      end
      pp <= ser_p;
      if (sh[39:10] === exp30) hit <= 1'b1;
      if (trs_found === 1'b1) trs_cnt <= trs_cnt + 1;
   end

   task automatic chk(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         errors++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask : chk

   task automatic put(input logic [9:0] w);
      next_word = w;
      @(posedge took);
   endtask : put

   task automatic wait_lock(input logic v, input int lim);
      int n;
      n = 0;
      while (lock_detect !== v && n < lim) begin
         @(negedge core_clk);
         n++;
      end
      chk(lock_detect === v, "lock level");
   endtask : wait_lock

   // five trailing words flush the three-word window and the shifter
   task automatic stream(input logic [29:0] e, input logic [9:0] a, b, c, f);
      exp30 = e;
      hit = 1'b0;
      put(a);
      put(b);
      put(c);
      repeat (5) put(f);
      chk(hit, "serial word stream");
   endtask : stream

   task automatic t_start();
      chk(ser_oe_n === 1'b1 && ser_n === 1'b1, "pair released in reset state");
      repeat (sdi_pkg::CLK_START_WAIT_CYC) @(negedge core_clk);
      chk(ser_oe_n === 1'b1 && lock_detect === 1'b0, "idle before clock");
      run = 1'b1;
      wait_lock(1'b1, sdi_pkg::LOCK_MAX_CYC);
      put(10'h200);
   endtask : t_start

   task automatic t_narrow();
      logic [9:0] ff;
      narrow_word = 1'b1;
      for (int t = 0; t < 3; t++) begin
         data_type = t[1:0];
         ff = (data_type == sdi_pkg::TYPE_COMPONENT) ? 10'h3FC : 10'h3FF;
         stream({10'h004, ff, 10'h168}, 10'h16B, 10'h3FF, 10'h007, 10'h200);
      end
      narrow_word = 1'b0;
      data_type = sdi_pkg::TYPE_COMPONENT;
   endtask : t_narrow

   task automatic t_trs();
      int n0;
      n0 = trs_cnt;
      trs_detect_en_n = 1'b0;
      stream({10'h000, 10'h000, 10'h3FF}, 10'h3FD, 10'h002, 10'h001, 10'h200);
      chk(trs_cnt == n0 + 1 && video_active === 1'b1, "start of video");
      stream({10'h000, 10'h000, 10'h3FF}, 10'h3FC, 10'h003, 10'h000, 10'h240);
      chk(trs_cnt == n0 + 2 && video_active === 1'b0, "end of video");
      trs_detect_en_n = 1'b1;
      stream({10'h001, 10'h002, 10'h3FD}, 10'h3FD, 10'h002, 10'h001, 10'h200);
      chk(trs_cnt == n0 + 2 && video_active === 1'b0, "detection disabled");
   endtask : t_trs

   task automatic t_unlock();
      logic p1;
      period = 5'h0C;
      wait_lock(1'b0, 60);
      p1 = ser_p;
      repeat (20) @(negedge core_clk);
      chk(ser_p === p1, "static output while unlocked");
      period = 5'h0A;
      wait_lock(1'b1, sdi_pkg::LOCK_MAX_CYC);
      put(10'h200);
   endtask : t_unlock

   task automatic finish_test();
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test

   initial begin
      #2_000_000;
      errors++;
      finish_test();
   end

   initial begin
      rst_n = 1'b0;
      run = 1'b0;
      period = 5'h0A;
      next_word = 10'h200;
      narrow_word = 1'b0;
      data_type = sdi_pkg::TYPE_COMPONENT;
      trs_detect_en_n = 1'b1;
      repeat (10) @(negedge core_clk);
      rst_n = 1'b1;
      t_start();
      stream({10'h0F0, 10'h2AA, 10'h155}, 10'h155, 10'h2AA, 10'h0F0, 10'h200);
      stream({10'h3C1, 10'h001, 10'h200}, 10'h200, 10'h001, 10'h3C1, 10'h0FF);
      t_narrow();
      t_trs();
      t_unlock();
      stream({10'h011, 10'h322, 10'h133}, 10'h133, 10'h322, 10'h011, 10'h200);
      rst_n = 1'b0;
      run = 1'b0;
      @(negedge core_clk);
      chk(ser_oe_n === 1'b1 && lock_detect === 1'b0 && video_active === 1'b0, "reset");
      finish_test();
   end
endmodule : sdi_serializer_encoder_tb_top
